// >>> bench/fcs_flash_model.sv
// behavioural flash device answering the host bus cycles
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter logic [15:0] SIG_WORD = 16'h5A3C, // arbitrary value
    parameter logic [15:0] QRY_WORD = 16'h0E71, // arbitrary value
    parameter int ERASE_READS = 12
) (
    // bus pins
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    // fault select: bit 0 program or erase fail, bit 1 low supply with program fail, on program only
    input wire logic [1:0] fault_in
);
    // ----------------
    // device state
    // ----------------
    logic [1:0] mode_q = 2'h0;
    logic [7:0] pend_q = 8'h00;
    logic [7:0] err_q = 8'h00;
    logic [15:0] word_q = 16'hFFFF;
    logic [15:0] out_q = 16'h0000;
    logic lock_q = 1'b1;
    logic psus_q = 1'b0;
    logic esus_q = 1'b0;
    int pb_q = 0;
    int eb_q = 0;
    wire logic rdy = !((pb_q != 0 && !psus_q) || (eb_q != 0 && !esus_q));
    wire logic [7:0] sr = err_q | {rdy, esus_q, 3'h0, psus_q, 2'h1};
    // a released bus shows the inverse word, so stale data never passes
    assign #5 dq_out = (ce_n_in || oe_n_in) ? ~out_q : out_q;
    always @(negedge oe_n_in) begin
        if (!rdy || mode_q == 2'h3) out_q = {8'h00, sr};
        else out_q = mode_q == 2'h1 ? SIG_WORD : mode_q == 2'h2 ? QRY_WORD : word_q;
        if (pb_q != 0 && !psus_q) pb_q--;
        else if (eb_q != 0 && !esus_q) eb_q--;
    end
    always @(negedge we_n_in) begin : wr
        logic [7:0] p;
        logic [7:0] c;
        p = pend_q;
        c = dq_in[7:0];
        pend_q = 8'h00;
        if (p != 8'h00) mode_q = 2'h3;
        if ((p == 8'h40 || p == 8'h20) && lock_q) err_q[1] = 1'b1;
        else if (p == 8'h40) begin
            word_q = dq_in;
            pb_q = 2;
            err_q[4:3] = err_q[4:3] | {|fault_in, fault_in[1]};
        end
        else if (p == 8'h20 && c != 8'hD0) err_q = err_q | 8'h30;
        else if (p == 8'h20) begin
            eb_q = fault_in[0] ? 0 : ERASE_READS;
            err_q[5] = err_q[5] | fault_in[0];
        end
        else if (p == 8'h60) lock_q = c != 8'hD0;
        else if (p == 8'hC0) pb_q = 1;
        else begin
            if (c inside {8'h70, 8'hB0, 8'hD0, 8'h40, 8'h10, 8'h20, 8'h60, 8'hC0}) mode_q = 2'h3;
            if (c inside {8'h40, 8'h20, 8'h60, 8'hC0}) pend_q = c;
            if (c == 8'h10) pend_q = 8'h40;
            if (c == 8'hFF) mode_q = 2'h0;
            if (c == 8'h90) mode_q = 2'h1;
            if (c == 8'h98) mode_q = 2'h2;
            if (c == 8'h50) err_q = 8'h00;
            if (c == 8'hB0 && pb_q != 0) psus_q = 1'b1;
            else if (c == 8'hB0) esus_q = eb_q != 0;
            if (c == 8'hD0 && psus_q) psus_q = 1'b0;
            else if (c == 8'hD0) esus_q = 1'b0;
        end
    end
endmodule : fcs_flash_model

// >>> bench/fcs_host_assertions.sv
// port checker for the flash command host
`timescale 1ns/1ps
module fcs_host_assertions
    import fcs_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire fcs_op_t req_op_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [7:0] rsp_status_out,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_we_n_out,
    input wire logic flash_wp_n_out
);
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic take = req_valid_in && req_ready_out;
    property cmd_p(fcs_op_t op, logic [15:0] w);
        take && req_op_in == op |-> ##[2:4] (!flash_we_n_out && flash_dq_out == w);
    endproperty
    status_cmd_a: assert property (cmd_p(FCS_OP_READ_STATUS, 16'h0070))
        else $error("bad status code");
    clear_cmd_a: assert property (cmd_p(FCS_OP_CLEAR_STATUS, 16'h0050))
        else $error("bad clear code");
    suspend_cmd_a: assert property (cmd_p(FCS_OP_SUSPEND, 16'h00B0))
        else $error("bad suspend code");
    erase_confirm_a: assert property (take && req_op_in == FCS_OP_ERASE |->
        ##[5:8] (!flash_we_n_out && flash_dq_out == 16'h00D0)) else $error("bad confirm");
    guard_unlock_a: assert property (take && req_op_in == FCS_OP_UNLOCK |->
        ##[1:3] flash_wp_n_out [*5]) else $error("guard too short");
    guard_idle_a: assert property (req_ready_out |-> !flash_wp_n_out)
        else $error("guard high while idle");
    poll_toggle_a: assert property (!flash_oe_n_out |=> flash_oe_n_out)
        else $error("read strobe not toggled");
    status_mask_a: assert property (rsp_valid_out |-> !rsp_status_out[0])
        else $error("reserved bit not masked");
    cover property (take && req_op_in == FCS_OP_UNLOCK);
    cover property (rsp_valid_out && rsp_status_out[6]);
    cover property (rsp_valid_out && rsp_status_out[1]);
endmodule : fcs_host_assertions

bind fcs_host fcs_host_assertions fcs_host_assertions_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_status_out(rsp_status_out), .flash_dq_out(flash_dq_out),
    .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
    .flash_wp_n_out(flash_wp_n_out)
);

// >>> bench/fcs_host_tb.sv
// bench for the flash command host against a device model
`timescale 1ns/1ps
module fcs_host_tb;
    import fcs_pkg::*;
    // ----------------
    // signals and instances
    // ----------------
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    fcs_op_t req_op_in = FCS_OP_READ;
    logic [19:0] req_addr_in = 20'h00000;
    logic [15:0] req_data_in = 16'h0000;
    logic [1:0] fault = 2'h0;
    logic req_ready_out, rsp_valid_out, rsp_error_out, rsp_timeout_out;
    logic [15:0] rsp_data_out, flash_dq_out;
    logic [7:0] rsp_status_out;
    logic [19:0] flash_addr_out;
    logic flash_dq_oe_n_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_wp_n_out;
    wire logic [15:0] dev_dq;
    wire logic [15:0] bus = flash_dq_oe_n_out ? dev_dq : flash_dq_out;
    int n_mismatch = 0;
    int checked = 0;
    fcs_host #(.ADDR_W(20), .POLL_MAX(8)) fcs_host_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .rsp_status_out(rsp_status_out),
        .rsp_error_out(rsp_error_out), .rsp_timeout_out(rsp_timeout_out),
        .flash_addr_out(flash_addr_out), .flash_dq_in(bus), .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n_out(flash_dq_oe_n_out), .flash_ce_n_out(flash_ce_n_out),
        .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
        .flash_wp_n_out(flash_wp_n_out)
    );
    fcs_flash_model fcs_flash_model_i (
        .dq_in(bus), .dq_out(dev_dq), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
        .we_n_in(flash_we_n_out), .fault_in(fault)
    );
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one request, held until taken, then a bounded wait for the answer
    task automatic run(input fcs_op_t op, input logic [15:0] data);
        int n;
        n = 0;
        while (req_ready_out !== 1'b1) @(posedge clk_in) #10;
        req_op_in = op;
        req_data_in = data;
        req_addr_in = {4'h2, data};
        req_valid_in = 1'b1;
        @(posedge clk_in) #10;
        req_valid_in = 1'b0;
        while (rsp_valid_out !== 1'b1 && n < 300) begin
            @(posedge clk_in) #10;
            n++;
        end
        if (n == 300) chk(rsp_valid_out, 16'h0001);
        chk(flash_addr_out[15:0], data);
    endtask : run
    task automatic rd(input fcs_op_t mode, input logic [15:0] exp);
        run(mode, 16'h0000);
        run(FCS_OP_READ, 16'h0000);
        chk(rsp_data_out, exp);
    endtask : rd
    task automatic op_poll(input fcs_op_t op, input logic [15:0] data, input logic [7:0] st);
        run(op, data);
        run(FCS_OP_POLL, 16'h0000);
        chk({8'h00, rsp_status_out}, {8'h00, st});
        chk(rsp_error_out, |(st & 8'h3A));
        chk(rsp_timeout_out, 16'h0000);
    endtask : op_poll
    task automatic t_modes();
        rd(FCS_OP_READ_ID, 16'h5A3C);
        rd(FCS_OP_QUERY, 16'h0E71);
        rd(FCS_OP_READ_STATUS, 16'h0081);
        chk(rsp_status_out, 16'h0080);
        rd(FCS_OP_READ_ARRAY, 16'hFFFF);
    endtask : t_modes
    task automatic t_locked();
        op_poll(FCS_OP_PROGRAM, 16'h1357, 8'h82);
        op_poll(FCS_OP_READ_STATUS, 16'h0000, 8'h82);
        op_poll(FCS_OP_CLEAR_STATUS, 16'h0000, 8'h80);
        op_poll(FCS_OP_UNLOCK, 16'h0000, 8'h80);
        op_poll(FCS_OP_PROGRAM, 16'h1357, 8'h80);
        rd(FCS_OP_READ_ARRAY, 16'h1357);
        op_poll(FCS_OP_PROT_PROGRAM, 16'h2468, 8'h80);
        op_poll(FCS_OP_PROT_LOCK, 16'h0000, 8'h80);
    endtask : t_locked
    task automatic t_faults();
        fault = 2'h1;
        op_poll(FCS_OP_PROGRAM, 16'h0F0F, 8'h90);
        fault = 2'h2;
        op_poll(FCS_OP_CLEAR_STATUS, 16'h0000, 8'h80);
        op_poll(FCS_OP_PROGRAM, 16'h0F0F, 8'h98);
        fault = 2'h0;
        op_poll(FCS_OP_CLEAR_STATUS, 16'h0000, 8'h80);
        op_poll(FCS_OP_LOCK, 16'h0000, 8'h80);
        op_poll(FCS_OP_ERASE, 16'h0000, 8'h82);
        op_poll(FCS_OP_LOCK_DOWN, 16'h0000, 8'h82);
        op_poll(FCS_OP_CLEAR_STATUS, 16'h0000, 8'h80);
        op_poll(FCS_OP_UNLOCK, 16'h0000, 8'h80);
        fault = 2'h1;
        op_poll(FCS_OP_ERASE, 16'h0000, 8'hA0);
        fault = 2'h0;
        op_poll(FCS_OP_CLEAR_STATUS, 16'h0000, 8'h80);
    endtask : t_faults
    task automatic t_suspend();
        run(FCS_OP_ERASE, 16'h0000);
        op_poll(FCS_OP_SUSPEND, 16'h0000, 8'hC0);
        run(FCS_OP_PROGRAM, 16'h0C0C);
        op_poll(FCS_OP_SUSPEND, 16'h0000, 8'hC4);
        op_poll(FCS_OP_RESUME, 16'h0000, 8'hC0);
        run(FCS_OP_RESUME, 16'h0000);
        run(FCS_OP_POLL, 16'h0000);
        chk(rsp_timeout_out, 16'h0001);
        op_poll(FCS_OP_READ_STATUS, 16'h0000, 8'h80);
    endtask : t_suspend
    task automatic print_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        #10;
        rst_n_in = 1'b1;
        t_modes();
        t_locked();
        t_faults();
        t_suspend();
        print_verdict();
    end
endmodule : fcs_host_tb

// >>> hdl/fcs_host.sv
// host controller that issues flash command sequences over the parallel pins
`timescale 1ns/1ps
`include "fcs_regs.svh"

module fcs_host
    import fcs_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int POLL_MAX = 65535
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // user command port
    input wire logic req_valid_in,
    input wire fcs_op_t req_op_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [15:0] req_data_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    output logic [7:0] rsp_status_out,
    output logic rsp_error_out,
    output logic rsp_timeout_out,
    // flash pins
    output logic [ADDR_W-1:0] flash_addr_out,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_n_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    output logic flash_wp_n_out
);
    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam logic [2:0] SETUP_CYC = 3'((`FCS_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS);
    localparam logic [2:0] STROBE_CYC = 3'((`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS);
    localparam logic [2:0] HOLD_CYC = 3'((`FCS_HOLD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fcs_state_t state_q, state_d;
    fcs_op_t op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0] data_q;
    logic [2:0] cnt_q, cnt_d;
    logic phase_q;
    logic read_q;
    logic [15:0] dq_q;
    logic [ADDR_W-1:0] pin_addr_q;
    logic ce_n_q, oe_n_q, we_n_q, dq_oe_n_q, wp_n_q;
    logic ready_q, rsp_valid_q, rsp_err_q, rsp_to_q;
    logic [15:0] rsp_data_q;
    logic [7:0] rsp_status_q;
    logic [15:0] poll_cnt_q;

    // ----------------------------------------------------------------
    // decode of the user operation into one or two bus cycles
    // ----------------------------------------------------------------
    wire is_poll = (op_q == FCS_OP_POLL);
    wire two_cycle = (op_q == FCS_OP_PROGRAM) || (op_q == FCS_OP_ERASE) ||
                     (op_q == FCS_OP_LOCK) || (op_q == FCS_OP_UNLOCK) ||
                     (op_q == FCS_OP_LOCK_DOWN) || (op_q == FCS_OP_PROT_PROGRAM) ||
                     (op_q == FCS_OP_PROT_LOCK);
    wire is_unlock = (op_q == FCS_OP_UNLOCK);
    logic [7:0] first_code;
    always_comb begin
        unique case (op_q)
            FCS_OP_READ_ARRAY: first_code = `FCS_CMD_READ_ARRAY;
            FCS_OP_READ_ID: first_code = `FCS_CMD_READ_ID;
            FCS_OP_QUERY: first_code = `FCS_CMD_QUERY;
            FCS_OP_READ_STATUS: first_code = `FCS_CMD_READ_STATUS;
            FCS_OP_CLEAR_STATUS: first_code = `FCS_CMD_CLEAR_STATUS;
            FCS_OP_PROGRAM: first_code = `FCS_CMD_PROGRAM;
            FCS_OP_ERASE: first_code = `FCS_CMD_ERASE;
            FCS_OP_SUSPEND: first_code = `FCS_CMD_SUSPEND;
            FCS_OP_RESUME: first_code = `FCS_CMD_CONFIRM;
            FCS_OP_LOCK, FCS_OP_UNLOCK, FCS_OP_LOCK_DOWN: first_code = `FCS_CMD_LOCK_SETUP;
            FCS_OP_PROT_PROGRAM, FCS_OP_PROT_LOCK: first_code = `FCS_CMD_PROT_PROGRAM;
            FCS_OP_READ, FCS_OP_POLL: first_code = `FCS_CMD_READ_ARRAY;
        endcase
    end
    logic [15:0] second_word;
    always_comb begin
        unique case (op_q)
            FCS_OP_ERASE, FCS_OP_UNLOCK: second_word = {`FCS_UPPER_ZERO, `FCS_CMD_CONFIRM};
            FCS_OP_LOCK: second_word = {`FCS_UPPER_ZERO, `FCS_CMD_LOCK};
            FCS_OP_LOCK_DOWN: second_word = {`FCS_UPPER_ZERO, `FCS_CMD_LOCK_DOWN};
            FCS_OP_PROT_LOCK: second_word = `FCS_PROT_LOCK_WORD;
            default: second_word = data_q;
        endcase
    end
    // first write goes to any address: the target is reused so one bus stays stable
    wire [15:0] write_word = phase_q ? second_word : {`FCS_UPPER_ZERO, first_code};
    // masking bit 0 avoids acting on a reserved bit
    wire [7:0] status_seen = flash_dq_in[7:0] & `FCS_SR_VALID_MASK;
    wire engine_ready = status_seen[`FCS_SR_READY];
    wire seq_error = status_seen[`FCS_SR_READY] && status_seen[`FCS_SR_PROG_FAIL] &&
                     status_seen[`FCS_SR_ERASE_FAIL];
    wire op_failed = seq_error || status_seen[`FCS_SR_ERASE_FAIL] ||
                     status_seen[`FCS_SR_PROG_FAIL] || status_seen[`FCS_SR_SUPPLY_LOW] ||
                     status_seen[`FCS_SR_LOCKED];
    // the count holds finished reads before this one, so the last allowed read is POLL_MAX
    wire poll_expired = (poll_cnt_q == 16'(POLL_MAX - 1));
    wire last_phase = read_q || !two_cycle || phase_q;
    wire poll_again = is_poll && !engine_ready && !poll_expired;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            FCS_ST_IDLE: if (req_valid_in) begin
                state_d = FCS_ST_SETUP;
                cnt_d = SETUP_CYC;
            end
            FCS_ST_SETUP: if (cnt_q <= 3'h1) begin
                state_d = FCS_ST_STROBE;
                cnt_d = STROBE_CYC;
            end else begin
                cnt_d = cnt_q - 3'h1;
            end
            FCS_ST_STROBE: if (cnt_q <= 3'h1) begin
                state_d = FCS_ST_HOLD;
                cnt_d = HOLD_CYC;
            end else begin
                cnt_d = cnt_q - 3'h1;
            end
            FCS_ST_HOLD: if (cnt_q > 3'h1) begin
                cnt_d = cnt_q - 3'h1;
            end else if (!last_phase || poll_again) begin
                // each poll raises oe so the device latches a fresh status
                state_d = FCS_ST_SETUP;
                cnt_d = SETUP_CYC;
            end else if (is_unlock) begin
                state_d = FCS_ST_GUARD;
                cnt_d = `FCS_GUARD_EXTRA;
            end else begin
                state_d = FCS_ST_DONE;
            end
            FCS_ST_GUARD: if (cnt_q <= 3'h1) begin
                state_d = FCS_ST_DONE;
            end else begin
                cnt_d = cnt_q - 3'h1;
            end
            FCS_ST_DONE: state_d = FCS_ST_IDLE;
            // unused codes of the state word recover to idle
            default: state_d = FCS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= FCS_ST_IDLE;
            cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // request capture and phase tracking
    // ----------------------------------------------------------------
    wire take = (state_q == FCS_ST_IDLE) && req_valid_in;
    wire hold_end = (state_q == FCS_ST_HOLD) && (cnt_q <= 3'h1);
    wire take_read = (req_op_in == FCS_OP_READ) || (req_op_in == FCS_OP_POLL);

    // the request is copied so the user port may change while the bus runs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_q <= FCS_OP_READ_ARRAY;
            addr_q <= '0;
            data_q <= 16'h0000;
            read_q <= 1'b0;
        end else if (take) begin
            op_q <= req_op_in;
            addr_q <= req_addr_in;
            data_q <= req_data_in;
            read_q <= take_read;
        end
    end

    // the second write of a pair follows once the first hold ends
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= 1'b0;
        end else if (take) begin
            phase_q <= 1'b0;
        end else if (hold_end) begin
            phase_q <= !read_q && two_cycle;
        end
    end

    // one count per finished bus cycle bounds a poll of a stuck device
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            poll_cnt_q <= 16'h0000;
        end else if (take) begin
            poll_cnt_q <= 16'h0000;
        end else if (hold_end) begin
            poll_cnt_q <= poll_cnt_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // pins; wp held high from the first unlock write until one cycle past the second
    // ----------------------------------------------------------------
    wire strobe = (state_q == FCS_ST_STROBE);
    wire active = (state_q != FCS_ST_IDLE) && (state_q != FCS_ST_DONE);
    wire guard_on = is_unlock && active;
    wire ce_on = strobe || (state_q == FCS_ST_HOLD && cnt_q > 3'h1);
    wire oe_on = strobe && read_q;
    wire we_on = strobe && !read_q;
    wire drive_on = active && !read_q;

    // address follows the captured request every cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_addr_q <= '0;
        end else begin
            pin_addr_q <= addr_q;
        end
    end

    // write word is set up a cycle ahead of we and held past its rise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dq_q <= 16'h0000;
        end else begin
            dq_q <= write_word;
        end
    end

    // data lines are driven for the whole write sequence, never during reads
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dq_oe_n_q <= 1'b1;
        end else begin
            dq_oe_n_q <= !drive_on;
        end
    end

    // strobes rest high; oe falls with ce so the device latches on that edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
        end else begin
            ce_n_q <= !ce_on;
            oe_n_q <= !oe_on;
            we_n_q <= !we_on;
        end
    end

    // guard pin rests low so locked-down blocks stay protected between requests
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_n_q <= 1'b0;
        end else begin
            wp_n_q <= guard_on;
        end
    end

    // ----------------------------------------------------------------
    // answer
    // ----------------------------------------------------------------
    wire sample = (state_q == FCS_ST_HOLD) && (cnt_q == HOLD_CYC) && read_q;
    // ready rises with the answer strobe, so the next request can follow at once
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
        end else begin
            ready_q <= (state_d == FCS_ST_IDLE);
            rsp_valid_q <= (state_q == FCS_ST_DONE);
        end
    end

    // read results hold until the next read so a slow user can still pick them up
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_data_q <= 16'h0000;
            rsp_status_q <= 8'h00;
            rsp_err_q <= 1'b0;
            rsp_to_q <= 1'b0;
        end else if (sample) begin
            rsp_data_q <= flash_dq_in;
            rsp_status_q <= status_seen;
            // result bits trusted only once ready reads 1
            rsp_err_q <= is_poll && engine_ready && op_failed;
            rsp_to_q <= is_poll && !engine_ready && poll_expired;
        end
    end

    // user side
    assign req_ready_out = ready_q;
    assign rsp_valid_out = rsp_valid_q;
    assign rsp_data_out = rsp_data_q;
    assign rsp_status_out = rsp_status_q;
    assign rsp_error_out = rsp_err_q;
    assign rsp_timeout_out = rsp_to_q;

    // device side
    assign flash_addr_out = pin_addr_q;
    assign flash_dq_out = dq_q;
    assign flash_dq_oe_n_out = dq_oe_n_q;
    assign flash_ce_n_out = ce_n_q;
    assign flash_oe_n_out = oe_n_q;
    assign flash_we_n_out = we_n_q;
    assign flash_wp_n_out = wp_n_q;
endmodule : fcs_host

// >>> hdl/fcs_pkg.sv
// types for the flash command host
package fcs_pkg;
    typedef enum logic [3:0] {
        FCS_OP_READ_ARRAY,
        FCS_OP_READ_ID,
        FCS_OP_QUERY,
        FCS_OP_READ_STATUS,
        FCS_OP_CLEAR_STATUS,
        FCS_OP_PROGRAM,
        FCS_OP_ERASE,
        FCS_OP_SUSPEND,
        FCS_OP_RESUME,
        FCS_OP_LOCK,
        FCS_OP_UNLOCK,
        FCS_OP_LOCK_DOWN,
        FCS_OP_PROT_PROGRAM,
        FCS_OP_PROT_LOCK,
        FCS_OP_READ,
        FCS_OP_POLL
    } fcs_op_t;

    typedef enum logic [2:0] {
        FCS_ST_IDLE,
        FCS_ST_SETUP,
        FCS_ST_STROBE,
        FCS_ST_HOLD,
        FCS_ST_GUARD,
        FCS_ST_DONE
    } fcs_state_t;
endpackage : fcs_pkg

// >>> hdl/fcs_regs.svh
// command codes, status bit positions and timing counts for the flash command host
//
// Operation
// - write 90h anywhere enters identifier read mode.
// - write 70h anywhere selects status reads.
// - write 50h anywhere clears status error flags.
// - word program: 40h or 10h, then address and data; prefer 40h.
// - block erase: 20h, then D0h at an address inside the block.
// - write B0h anywhere requests suspend of program or erase.
// - write D0h anywhere resumes a suspended operation.
// - host holds write-guard for seven cycles, one past the second write of unlock.
// - protection program: C0h then data; lock: C0h then FFFD at lock address.
// - bit 0 is reserved; host masks it when polling.
// - status latched on later falling edge of OE or CE; toggle per poll.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

`define FCS_CMD_READ_ARRAY 8'hFF
`define FCS_CMD_READ_ID 8'h90
`define FCS_CMD_QUERY 8'h98
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PROGRAM 8'h40
`define FCS_CMD_PROGRAM_ALT 8'h10
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_CONFIRM 8'hD0
`define FCS_CMD_SUSPEND 8'hB0
`define FCS_CMD_LOCK_SETUP 8'h60
`define FCS_CMD_LOCK 8'h01
`define FCS_CMD_LOCK_DOWN 8'h2F
`define FCS_CMD_PROT_PROGRAM 8'hC0
`define FCS_PROT_LOCK_WORD 16'hFFFD
`define FCS_UPPER_ZERO 8'h00

`define FCS_SR_READY 7
`define FCS_SR_ERASE_HALT 6
`define FCS_SR_ERASE_FAIL 5
`define FCS_SR_PROG_FAIL 4
`define FCS_SR_SUPPLY_LOW 3
`define FCS_SR_PROG_HALT 2
`define FCS_SR_LOCKED 1
`define FCS_SR_VALID_MASK 8'hFE

// bus phase lengths in ns at 100 ns clock; each phase is one cycle minimum
`define FCS_CLK_NS 100
`define FCS_SETUP_NS 100
`define FCS_STROBE_NS 100
`define FCS_HOLD_NS 100
`define FCS_GUARD_EXTRA 3'h1

`endif
